// file: hdl/spw_pkg.sv
// Constants for the self polling wake-up channel scan sequencer
package spw_pkg;
	// Register addresses
	localparam logic [7:0] SPW_ADDR_FOUND_CH   = 8'h06;
	localparam logic [7:0] SPW_ADDR_A_MOD      = 8'h21;
	localparam logic [7:0] SPW_ADDR_A_CH1      = 8'h22;
	localparam logic [7:0] SPW_ADDR_A_CH2      = 8'h23;
	localparam logic [7:0] SPW_ADDR_A_CH3      = 8'h24;
	localparam logic [7:0] SPW_ADDR_B_MOD      = 8'h42;
	localparam logic [7:0] SPW_ADDR_B_CH1      = 8'h43;
	localparam logic [7:0] SPW_ADDR_B_CH2      = 8'h44;
	localparam logic [7:0] SPW_ADDR_B_CH3      = 8'h45;
	// Reset values
	localparam logic [7:0] SPW_RST_FOUND_CH    = 8'h00;
	localparam logic [7:0] SPW_RST_MOD         = 8'h04;
	localparam logic [7:0] SPW_RST_CH1         = 8'h29;
	localparam logic [7:0] SPW_RST_CH2         = 8'h08;
	localparam logic [7:0] SPW_RST_CH3         = 8'h0a;
	// Field positions
	localparam int         SPW_MT_LSB          = 0;
	localparam int         SPW_NOC_LSB         = 2;
	localparam int         SPW_DIV_S_LSB       = 0;
	localparam int         SPW_DIV_R_LSB       = 2;
	// Modulation select encodings
	localparam logic [1:0] SPW_MT_ASK          = 2'h0;
	localparam logic [1:0] SPW_MT_FSK          = 2'h1;
	localparam logic [1:0] SPW_MT_FSK_POLL     = 2'h2;
	// Channel settle wait: 9*64 system clock periods, about 40 us
	localparam int         SPW_SETTLE_BLOCKS   = 9;
	localparam int         SPW_SETTLE_BLOCK    = 64;
	localparam int         SPW_SETTLE_CYCLES   = SPW_SETTLE_BLOCKS * SPW_SETTLE_BLOCK;
	localparam int         SPW_CNT_W           = 10;

	typedef enum {
		SPW_IDLE,
		SPW_WAIT_PWR,
		SPW_INIT_LOOP,
		SPW_MOD_SW,
		SPW_INIT_RX,
		SPW_LOAD_CH,
		SPW_SETTLE,
		SPW_SEARCH,
		SPW_SEARCH_WAIT,
		SPW_STORE,
		SPW_COMPARE,
		SPW_INCR,
		SPW_RUN
	} spw_state_e;
endpackage

// file: hdl/spw_scan.sv
// Self polling wake-up channel scan sequencer with its configuration registers
// What this block does
// [R1] Stay idle until the polling timer raises receiver run, then leave idle.
// [R2] Wait for the start-up sequencer to finish powering the receiver.
// [R3] Reset loop counter to channel 1 of configuration A; counter selects channel.
// [R4] Set receiver modulation from the active configuration's modulation field.
// [R5] Then initialise the receiver with the active configuration's settings.
// [R6] Load channel 1 divider factors, wait 9*64 clocks before searching.
// [R7] Run the chosen wake-up search; success stores channel, else compare.
// [R8] On wake-up write current channel to status, then enter run mode.
// [R9] At count end go idle, or restart with configuration B when dual enabled.
// [R10] Increment state advances the loop counter by one.
// [R11] Channels 2 and 3 load their divider factors, then wait 9*64 clocks.
// [R12] After configuration A fails, optionally scan configuration B the same way.
// [R13] With a single configuration, settings always come from configuration A.
// [R14] Found-channel field reads 0 until the first wake-up, then 1 to 3 for the last wake-up channel.
// [R15] Channel count field bits 3:2 gives 1 to 3 channels, self polling only.
// [R16] Modulation field: 00 ASK, 01 FSK, 10 FSK while polling else ASK.
// [R17] After a wake-up, modulation switches automatically to the run-mode type.
// [R18] Host programs divider R in bits 4:2 and S in bits 1:0 per channel.
// [R19] Host sets operating mode select to one for self polling.
// [R20] Dual enable clear uses A only; set uses A then B.
// [R21] Channel 3 dividers sit in their own per-configuration registers.
// [R22] A polling cycle with no wake-up leaves the found-channel field unchanged.
`timescale 1ns/1ps
module spw_scan #(
	parameter int SCHEME_W = 2
) (
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	// Register port
	input  wire logic                 reg_wr_en,
	input  wire logic                 reg_rd_en,
	input  wire logic [7:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	output logic      [7:0]           reg_rdata,
	// Mode bits
	input  wire logic                 operating_mode_select,
	input  wire logic                 dual_config_enable,
	input  wire logic [SCHEME_W-1:0]  polling_scheme_select,
	input  wire logic                 permanent_wakeup_search_enable,
	// Polling timer and start-up sequencer
	input  wire logic                 rx_run,
	input  wire logic                 startup_done,
	input  wire logic                 run_exit,
	// Receiver control
	output logic                      rx_init,
	output logic                      rx_modulation_fsk,
	output logic                      cfg_b_active,
	output logic                      pll_load,
	output logic      [2:0]           ch_divider_r,
	output logic      [1:0]           ch_divider_s,
	// Wake-up search unit
	output logic                      search_start,
	output logic      [SCHEME_W-1:0]  search_scheme,
	output logic                      search_permanent,
	input  wire logic                 search_done,
	input  wire logic                 search_found,
	// Run mode self polling
	output logic                      run_self_polling
);
	import spw_pkg::*;

	typedef struct packed {
		spw_state_e              state;
		logic [1:0][7:0]         mod_reg;
		logic [1:0][2:0][7:0]    div_reg;
		logic [1:0]              found_channel_field;
		logic [1:0]              loop_cnt;
		logic                    cfg_b;
		logic [SPW_CNT_W-1:0]    settle_cnt;
		logic [7:0]              rdata;
		logic                    rx_init;
		logic                    fsk;
		logic                    pll_load;
		logic [2:0]              div_r;
		logic [1:0]              div_s;
		logic                    search_start;
		logic [SCHEME_W-1:0]     scheme;
		logic                    permanent;
		logic                    run;
	} spw_scan_s;

	localparam logic [SPW_CNT_W-1:0] SETTLE_LAST = SPW_CNT_W'(SPW_SETTLE_CYCLES - 1);

	spw_scan_s cur;
	spw_scan_s next_cur;

	logic [7:0] mod_act;
	logic [1:0] mt_act;
	logic [1:0] noc_act;
	logic [7:0] div_act;

	always_comb begin
		next_cur = cur;
		next_cur.rx_init = 1'b0;
		next_cur.pll_load = 1'b0;
		next_cur.search_start = 1'b0;
		mod_act = cur.mod_reg[cur.cfg_b]; // R13
		mt_act = mod_act[SPW_MT_LSB +: 2];
		noc_act = mod_act[SPW_NOC_LSB +: 2]; // R15
		if (noc_act == 2'h0) begin
			noc_act = 2'h1;
		end
		div_act = cur.div_reg[cur.cfg_b][cur.loop_cnt - 2'h1]; // R3 R21

		// Register writes; the found-channel status is read only
		if (reg_wr_en) begin
			case (reg_addr)
				SPW_ADDR_A_MOD: next_cur.mod_reg[0] = reg_wdata;
				SPW_ADDR_B_MOD: next_cur.mod_reg[1] = reg_wdata;
				SPW_ADDR_A_CH1: next_cur.div_reg[0][0] = reg_wdata; // R18
				SPW_ADDR_A_CH2: next_cur.div_reg[0][1] = reg_wdata;
				SPW_ADDR_A_CH3: next_cur.div_reg[0][2] = reg_wdata; // R21
				SPW_ADDR_B_CH1: next_cur.div_reg[1][0] = reg_wdata;
				SPW_ADDR_B_CH2: next_cur.div_reg[1][1] = reg_wdata;
				SPW_ADDR_B_CH3: next_cur.div_reg[1][2] = reg_wdata;
				default: begin
				end
			endcase
		end
		if (reg_rd_en && reg_addr == SPW_ADDR_FOUND_CH) begin
			next_cur.rdata = {6'h00, cur.found_channel_field}; // R14
		end else if (reg_rd_en) begin
			next_cur.rdata = 8'h00;
		end

		case (cur.state)
			SPW_IDLE: begin
				if (operating_mode_select && rx_run) begin // R1 R19
					next_cur.state = SPW_WAIT_PWR;
				end
			end
			SPW_WAIT_PWR: begin
				if (startup_done) begin // R2
					next_cur.cfg_b = 1'b0;
					next_cur.state = SPW_INIT_LOOP;
				end
			end
			SPW_INIT_LOOP: begin
				next_cur.loop_cnt = 2'h1; // R3
				next_cur.state = SPW_MOD_SW;
			end
			SPW_MOD_SW: begin
				next_cur.fsk = (mt_act == SPW_MT_FSK) || (mt_act == SPW_MT_FSK_POLL); // R4 R16
				next_cur.state = SPW_INIT_RX;
			end
			SPW_INIT_RX: begin
				next_cur.rx_init = 1'b1; // R5
				next_cur.state = SPW_LOAD_CH;
			end
			SPW_LOAD_CH: begin
				next_cur.div_r = div_act[SPW_DIV_R_LSB +: 3]; // R6 R11
				next_cur.div_s = div_act[SPW_DIV_S_LSB +: 2];
				next_cur.pll_load = 1'b1;
				next_cur.settle_cnt = '0;
				next_cur.state = SPW_SETTLE;
			end
			SPW_SETTLE: begin
				if (cur.settle_cnt == SETTLE_LAST) begin // R6 R11
					next_cur.state = SPW_SEARCH;
				end else begin
					next_cur.settle_cnt = cur.settle_cnt + SPW_CNT_W'(1);
				end
			end
			SPW_SEARCH: begin
				next_cur.scheme = polling_scheme_select; // R7
				next_cur.permanent = permanent_wakeup_search_enable;
				next_cur.search_start = 1'b1;
				next_cur.state = SPW_SEARCH_WAIT;
			end
			SPW_SEARCH_WAIT: begin
				if (search_done) begin // R7
					next_cur.state = search_found ? SPW_STORE : SPW_COMPARE;
				end
			end
			SPW_STORE: begin
				next_cur.found_channel_field = cur.loop_cnt; // R8 R14
				next_cur.fsk = (mt_act == SPW_MT_FSK); // R16 R17
				next_cur.run = 1'b1;
				next_cur.state = SPW_RUN;
			end
			SPW_COMPARE: begin
				if (cur.loop_cnt >= noc_act) begin // R9 R15
					if (dual_config_enable && !cur.cfg_b) begin // R12 R20
						next_cur.cfg_b = 1'b1;
						next_cur.state = SPW_INIT_LOOP;
					end else begin
						next_cur.cfg_b = 1'b0; // R13 R22
						next_cur.state = SPW_IDLE;
					end
				end else begin
					next_cur.state = SPW_INCR;
				end
			end
			SPW_INCR: begin
				next_cur.loop_cnt = cur.loop_cnt + 2'h1; // R10
				next_cur.state = SPW_LOAD_CH;
			end
			SPW_RUN: begin
				if (run_exit || !operating_mode_select) begin
					next_cur.run = 1'b0;
					next_cur.cfg_b = 1'b0;
					next_cur.state = SPW_IDLE;
				end
			end
			default: begin
				next_cur.state = SPW_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cur <= '{
				state: SPW_IDLE,
				mod_reg: {SPW_RST_MOD, SPW_RST_MOD},
				div_reg: {SPW_RST_CH3, SPW_RST_CH2, SPW_RST_CH1,
					SPW_RST_CH3, SPW_RST_CH2, SPW_RST_CH1},
				found_channel_field: SPW_RST_FOUND_CH[1:0],
				loop_cnt: 2'h1,
				cfg_b: 1'b0,
				settle_cnt: '0,
				rdata: 8'h00,
				rx_init: 1'b0,
				fsk: 1'b0,
				pll_load: 1'b0,
				div_r: 3'h0,
				div_s: 2'h0,
				search_start: 1'b0,
				scheme: '0,
				permanent: 1'b0,
				run: 1'b0
			};
		end else begin
			cur <= next_cur;
		end
	end

	assign reg_rdata         = cur.rdata;
	assign rx_init           = cur.rx_init;
	assign rx_modulation_fsk = cur.fsk;
	assign cfg_b_active      = cur.cfg_b;
	assign pll_load          = cur.pll_load;
	assign ch_divider_r      = cur.div_r;
	assign ch_divider_s      = cur.div_s;
	assign search_start      = cur.search_start;
	assign search_scheme     = cur.scheme;
	assign search_permanent  = cur.permanent;
	assign run_self_polling  = cur.run;
endmodule

// file: tb/spw_host.sv
// Host model driving the register port
`timescale 1ns/1ps
module spw_host (
	// Clock
	input wire logic sys_clk,
	// Register port
	output logic reg_wr_en = 1'b0,
	output logic reg_rd_en = 1'b0,
	output logic [7:0] reg_addr = 8'h0,
	output logic [7:0] reg_wdata = 8'h0,
	input wire logic [7:0] reg_rdata
);
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		reg_wr_en <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_wr_en <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~v;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		reg_rd_en <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd_en <= 1'b0;
		reg_addr <= ~a;
		// Read data is registered at the strobe edge and holds until the next read
		@(posedge sys_clk);
		v = reg_rdata;
	endtask
endmodule

// file: tb/spw_scan_properties.sv
// Port checker for the scan sequencer
`timescale 1ns/1ps
module spw_scan_props #(parameter int SCHEME_W = 2) (
	// Clock, reset, inputs and the search scheme output
	input wire logic sys_clk, rst, startup_done, run_exit,
	input wire logic permanent_wakeup_search_enable,
	input wire logic [SCHEME_W-1:0] polling_scheme_select, search_scheme,
	// Sequencer outputs and search answer
	input wire logic rx_init, pll_load, search_start, search_permanent,
	input wire logic search_done, search_found, run_self_polling
);
	logic [9:0] gap;
	// Cycles since the last divider load, saturating
	always_ff @(posedge sys_clk or posedge rst)
		if (rst) gap <= 10'h0;
		else gap <= pll_load ? 10'h1 : gap + {9'h0, gap != 10'h3ff};
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	settle_wait_a: assert property (search_start |-> gap == 10'h241)
		else $error("settle length wrong");
	load_gap_a: assert property (pll_load |=> !pll_load [*8])
		else $error("divider load repeated");
	init_load_a: assert property (rx_init |=> pll_load)
		else $error("no load after init");
	powered_up_a: assert property (rx_init |-> $past(startup_done, 4))
		else $error("init before power up");
	scheme_pass_a: assert property (search_start |-> search_scheme == $past(polling_scheme_select)
		&& search_permanent == $past(permanent_wakeup_search_enable)) else $error("scheme wrong");
	found_run_a: assert property (search_done && search_found && !run_self_polling
		|-> ##2 run_self_polling) else $error("run mode missing");
	run_quiet_a: assert property (run_self_polling |-> !search_start && !pll_load)
		else $error("scan active in run mode");
	exit_run_a: assert property (run_self_polling && run_exit |=> !run_self_polling)
		else $error("run mode not left");
	cover property (rx_init);
	cover property (search_done && search_found);
	cover property ($fell(run_self_polling));
endmodule
bind spw_scan spw_scan_props #(.SCHEME_W(SCHEME_W)) u_props (.*);

// file: tb/tb.sv
// Self-checking bench for the scan sequencer
`timescale 1ns/1ps
module tb;
	import spw_pkg::*;
	logic sys_clk = 1'b0, rst = 1'b1, rx_run = 1'b0, startup_done = 1'b0, run_exit = 1'b0;
	logic operating_mode_select = 1'b1, dual_config_enable = 1'b0;
	logic permanent_wakeup_search_enable = 1'b0, search_done = 1'b0, search_found = 1'b0;
	logic [1:0] polling_scheme_select = 2'h0, ch_divider_s, search_scheme;
	logic reg_wr_en, reg_rd_en, rx_init, rx_modulation_fsk, cfg_b_active, pll_load;
	logic search_start, search_permanent, run_self_polling;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d, status = 8'h0;
	logic [2:0] ch_divider_r;
	logic [7:0] mmod [2];
	logic [7:0] mdiv [2][3];
	int nl, cb, cc, hit_b, hit_ch, k, mismatches = 0, num_checks = 0;
	bit fin;
	always #5 sys_clk = ~sys_clk;
	spw_host host (.*);
	spw_scan dut (.*);
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	function int channel_count_field(input int b);
		return (mmod[b][3:2] == 2'h0) ? 1 : int'(mmod[b][3:2]);
	endfunction
	task cfg(input int b, input logic [7:0] m, d1, d2, d3);
		host.wr(b ? SPW_ADDR_B_MOD : SPW_ADDR_A_MOD, m);
		host.wr(b ? SPW_ADDR_B_CH1 : SPW_ADDR_A_CH1, d1);
		host.wr(b ? SPW_ADDR_B_CH2 : SPW_ADDR_A_CH2, d2);
		host.wr(b ? SPW_ADDR_B_CH3 : SPW_ADDR_A_CH3, d3);
		mmod[b] = m;
		mdiv[b] = '{d1, d2, d3};
	endtask
	// Search unit answers one cycle after each start; reference model of the scan order
	always @(posedge sys_clk) begin
		search_done <= search_start;
		search_found <= search_start && hit_ch == cc && hit_b == cb;
		if (search_done && !search_found && cc == channel_count_field(cb) && (cb || !dual_config_enable))
			fin = 1;
		if (pll_load === 1'b1) begin
			cb = dual_config_enable && nl >= channel_count_field(0);
			cc = cb ? nl - channel_count_field(0) + 1 : nl + 1;
			nl++;
			chk("cfg_b", cfg_b_active, cb[7:0]);
			chk("div", {ch_divider_r, ch_divider_s}, mdiv[cb][cc-1][4:0]);
			chk("fsk", rx_modulation_fsk, mmod[cb][1:0] inside {2'h1, 2'h2});
		end
	end
	task scan(input int hb, input int hc);
		hit_b = hb;
		hit_ch = hc;
		nl = 0;
		fin = 0;
		@(posedge sys_clk);
		rx_run <= 1'b1;
		polling_scheme_select <= 2'($urandom);
		permanent_wakeup_search_enable <= 1'($urandom);
		@(posedge sys_clk);
		rx_run <= 1'b0;
		repeat (6) @(posedge sys_clk);
		startup_done <= 1'b1;
		for (k = 0; k < 8000 && run_self_polling !== 1'b1 && !fin; k++) @(posedge sys_clk);
		chk("ended", k < 8000, 8'h1);
		repeat (4) @(posedge sys_clk);
		startup_done <= 1'b0;
		host.rd(SPW_ADDR_FOUND_CH, d);
		if (hc != 0) status = hc[7:0];
		chk("status", d, status);
		chk("run", run_self_polling, hc != 0);
		if (hc != 0) begin
			chk("run_fsk", rx_modulation_fsk, mmod[hb][1:0] == 2'h1);
			if (hb != 0) operating_mode_select <= 1'b0;
			else run_exit <= 1'b1;
			@(posedge sys_clk);
			operating_mode_select <= 1'b1;
			run_exit <= 1'b0;
			repeat (2) @(posedge sys_clk);
			chk("left_run", run_self_polling, 8'h0);
		end
	endtask
	initial begin
		void'($urandom(32'h73e0bd0e));
		for (int b = 0; b < 2; b++) begin
			mmod[b] = SPW_RST_MOD;
			mdiv[b] = '{SPW_RST_CH1, SPW_RST_CH2, SPW_RST_CH3};
		end
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		host.rd(SPW_ADDR_FOUND_CH, d);
		chk("rst_status", d, SPW_RST_FOUND_CH);
		host.rd(SPW_ADDR_A_MOD, d);
		chk("wo_read", d, 8'h0);
		host.wr(SPW_ADDR_FOUND_CH, 8'h03);
		host.wr(8'h7e, 8'hff);
		scan(0, 0);
		for (int i = 0; i < 4; i++) begin
			cfg(0, {4'h0, 2'($urandom_range(1, 3)), 2'(i)}, 8'($urandom), 8'($urandom), 8'($urandom));
			cfg(1, {4'h0, 2'($urandom_range(1, 3)), 2'(3-i)}, 8'($urandom), 8'($urandom), 8'($urandom));
			dual_config_enable <= (i == 1 || i == 2);
			scan(i == 2, i == 1 ? 0 : $urandom_range(1, channel_count_field(i == 2)));
		end
		stop_test;
	end
	initial begin
		repeat (60000) @(posedge sys_clk);
		mismatches++;
		stop_test;
	end
endmodule
